// >>> fan_pwm_ramp_smoothing.sv
// Operation
// - Local smoothing enable (bit 3) ramp-limits duty changes from the local channel.
// - Remote 2 ramp-rate field (bits 6:4) sets the top rate of Remote 2 duty changes, stepping gradually.
// - Fast timebase gives increments 1,2,3,4,8,12,24,48 with full ramps of 37.5 s down to 0.8 s.
// - Slow timebase keeps the increments over a longer slot, full ramps of 52.2 s down to 1.1 s.
// - Remote 2 smoothing enable (bit 7) ramp-limits duty changes from the Remote 2 channel.
// - Once the lock bit is one the register is read-only and later writes are ignored.
`include "fan_ramp_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module fan_pwm_ramp_smoothing #(
  parameter int unsigned SLOT_FAST = 32'(`SLOT_FAST_CYCLES),
  parameter int unsigned SLOT_SLOW = 32'(`SLOT_SLOW_CYCLES)
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  // AXI4-Lite slave
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // Requested duty from the fan control loop, same clock
  input  wire fan_ramp_pkg::duty_t  local_request_duty,
  input  wire fan_ramp_pkg::duty_t  remote2_request_duty,
  // Smoothed duty and drive waveform
  output var   fan_ramp_pkg::duty_t fan_duty_level,
  output logic                      fan_drive_output
);

  // Write channel state
  logic [7:0]            aw_addr_ff;
  logic                  aw_full_ff;
  // Only byte lane 0 carries register bits; upper lanes are dropped
  logic [7:0]            w_data_ff;
  logic                  w_lane0_ff;
  logic                  w_full_ff;
  logic                  bvalid_ff;
  logic [1:0]            bresp_ff;
  // Read channel state
  logic                  rvalid_ff;
  logic [31:0]           rdata_ff;
  logic [1:0]            rresp_ff;
  // Registers
  logic [7:0]            cfg_ff;
  logic [`CTRL_WIDTH-1:0] ctrl_ff;
  // Timebase and drive
  logic [31:0]           slot_cnt_ff;
  logic                  slow_q_ff;
  logic [7:0]            pwm_cnt_ff;
  logic                  drive_ff;
  fan_ramp_pkg::duty_t   level_ff;

  // Handshakes
  logic aw_take;
  logic w_take;
  logic wr_fire;
  logic ar_take;
  assign s_axi_awready = !aw_full_ff && !bvalid_ff;
  assign s_axi_wready  = !w_full_ff && !bvalid_ff;
  assign s_axi_arready = !rvalid_ff;
  assign aw_take       = s_axi_awvalid && s_axi_awready;
  assign w_take        = s_axi_wvalid && s_axi_wready;
  assign wr_fire       = aw_full_ff && w_full_ff && !bvalid_ff;
  assign ar_take       = s_axi_arvalid && s_axi_arready;

  // Byte-address match shared by the read and write decoders
  function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] ofs);
    return addr == ofs;
  endfunction

  // Address decode
  logic wr_cfg;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_hit;
  logic locked;
  logic cfg_we;
  logic ctrl_we;
  assign wr_cfg  = addr_is(aw_addr_ff, `OFS_RAMP_CFG_B);
  assign wr_ctrl = addr_is(aw_addr_ff, `OFS_RAMP_CTRL);
  assign wr_stat = addr_is(aw_addr_ff, `OFS_RAMP_STATUS);
  assign wr_hit  = wr_cfg || wr_ctrl || wr_stat;
  assign locked  = ctrl_ff[`CTRL_LOCK_BIT];
  // Locked writes still answer OKAY; the data is simply dropped
  assign cfg_we  = wr_fire && wr_cfg && w_lane0_ff && !locked;
  assign ctrl_we = wr_fire && wr_ctrl && w_lane0_ff && !locked;

  // Next control value; lock is sticky until reset
  logic [`CTRL_WIDTH-1:0] nxt_ctrl;
  assign nxt_ctrl = w_data_ff[`CTRL_WIDTH-1:0];

  // Fields
  logic                     local_en;
  logic                     r2_en;
  fan_ramp_pkg::ramp_code_t r2_code;
  fan_ramp_pkg::ramp_code_t local_code;
  logic                     slow_sel;
  assign local_en   = cfg_ff[`CFG_LOCAL_EN_BIT];
  assign r2_en      = cfg_ff[`CFG_R2_EN_BIT];
  assign r2_code    = cfg_ff[`CFG_R2_RATE_MSB:`CFG_R2_RATE_LSB];
  assign local_code = ctrl_ff[`CTRL_LRATE_MSB:`CTRL_LRATE_LSB];
  assign slow_sel   = ctrl_ff[`CTRL_SLOW_BIT];

  // Read decode
  logic                rd_cfg;
  logic                rd_ctrl;
  logic                rd_stat;
  logic                rd_hit;
  logic [31:0]         rd_word;
  logic [31:0]         rd_cfg_word;
  logic [31:0]         rd_ctrl_word;
  logic [31:0]         rd_stat_word;
  fan_ramp_pkg::duty_t local_duty;
  fan_ramp_pkg::duty_t r2_duty;
  assign rd_cfg       = addr_is(s_axi_araddr, `OFS_RAMP_CFG_B);
  assign rd_ctrl      = addr_is(s_axi_araddr, `OFS_RAMP_CTRL);
  assign rd_stat      = addr_is(s_axi_araddr, `OFS_RAMP_STATUS);
  assign rd_hit       = rd_cfg || rd_ctrl || rd_stat;
  assign rd_cfg_word  = {24'h000000, cfg_ff};
  assign rd_ctrl_word = {27'h0, ctrl_ff};
  assign rd_stat_word = {8'h00, level_ff, r2_duty, local_duty};
  assign rd_word = rd_cfg  ? rd_cfg_word :
                   rd_ctrl ? rd_ctrl_word :
                   rd_stat ? rd_stat_word :
                             32'h00000000;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_full_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
    end else if (aw_take) begin
      aw_full_ff <= 1'b1;
      aw_addr_ff <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_full_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      w_full_ff  <= 1'b0;
      w_data_ff  <= 8'h00;
      w_lane0_ff <= 1'b0;
    end else if (w_take) begin
      w_full_ff  <= 1'b1;
      w_data_ff  <= s_axi_wdata[7:0];
      w_lane0_ff <= s_axi_wstrb[0];
    end else if (wr_fire) begin
      w_full_ff  <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= `RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h00000000;
      rresp_ff  <= `RESP_OKAY;
    end else if (ar_take) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= rd_word;
      rresp_ff  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp  = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata  = rdata_ff;
  assign s_axi_rresp  = rresp_ff;

  // Configuration registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_ff <= `CFG_RESET;
    end else if (cfg_we) begin
      cfg_ff <= w_data_ff;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_ff <= `CTRL_RESET;
    end else if (ctrl_we) begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // Slot timebase; restarts when the timebase is switched
  // 32 bits hold the slow slot at the full clock rate
  // Shared tick: a channel's first step after enable lands anywhere within one slot
  logic [31:0] slot_last;
  logic        slot_tick;
  logic        slot_restart;
  logic [31:0] nxt_slot_cnt;
  assign slot_last    = slow_sel ? (SLOT_SLOW - 32'd1)
                                 : (SLOT_FAST - 32'd1);
  assign slot_restart = slow_sel != slow_q_ff;
  assign slot_tick    = !slot_restart && (slot_cnt_ff >= slot_last);
  assign nxt_slot_cnt = (slot_restart || slot_tick) ? 32'd0 : slot_cnt_ff + 32'd1;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      slot_cnt_ff <= 32'd0;
      slow_q_ff   <= 1'b0;
    end else begin
      slot_cnt_ff <= nxt_slot_cnt;
      slow_q_ff   <= slow_sel;
    end
  end

  // Per-channel slew limiters
  fan_ramp_pkg::duty_t local_incr;
  fan_ramp_pkg::duty_t r2_incr;
  assign local_incr = fan_ramp_pkg::ramp_incr(local_code);
  assign r2_incr    = fan_ramp_pkg::ramp_incr(r2_code);

  ramp_stepper local_step (
    .clk       (clk),
    .rst       (rst),
    .smooth_en (local_en),
    .slot_tick (slot_tick),
    .incr      (local_incr),
    .target    (local_request_duty),
    .duty      (local_duty)
  );

  ramp_stepper remote2_step (
    .clk       (clk),
    .rst       (rst),
    .smooth_en (r2_en),
    .slot_tick (slot_tick),
    .incr      (r2_incr),
    .target    (remote2_request_duty),
    .duty      (r2_duty)
  );

  // Hottest channel wins the fan
  fan_ramp_pkg::duty_t nxt_level;
  logic                nxt_drive;
  assign nxt_level = (local_duty > r2_duty) ? local_duty : r2_duty;
  // Full scale must hold high every period, not 255 of 256
  assign nxt_drive = (level_ff == `DUTY_MAX) || (pwm_cnt_ff < level_ff);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      level_ff <= 8'h00;
    end else begin
      level_ff <= nxt_level;
    end
  end

  // Free-running period counter, wraps every 256 clocks
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pwm_cnt_ff <= 8'h00;
    end else begin
      pwm_cnt_ff <= pwm_cnt_ff + 8'h01;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      drive_ff <= 1'b0;
    end else begin
      drive_ff <= nxt_drive;
    end
  end

  assign fan_duty_level   = level_ff;
  assign fan_drive_output = drive_ff;

endmodule // fan_pwm_ramp_smoothing

`default_nettype wire

// >>> fan_ramp_consts.svh
`ifndef FAN_RAMP_CONSTS_SVH
`define FAN_RAMP_CONSTS_SVH

// Register byte offsets
`define OFS_RAMP_CFG_B     8'h00
`define OFS_RAMP_CTRL      8'h04
`define OFS_RAMP_STATUS    8'h08

// Ramp configuration register fields
`define CFG_LOCAL_EN_BIT   3
`define CFG_R2_RATE_LSB    4
`define CFG_R2_RATE_MSB    6
`define CFG_R2_EN_BIT      7
`define CFG_RESET          8'h00

// Control register fields
`define CTRL_SLOW_BIT      0
`define CTRL_LOCK_BIT      1
`define CTRL_LRATE_LSB     2
`define CTRL_LRATE_MSB     4
`define CTRL_WIDTH         5
`define CTRL_RESET         5'h00

// Status register fields
`define STAT_LOCAL_LSB     0
`define STAT_R2_LSB        8
`define STAT_OUT_LSB       16

// AXI responses
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

// Timing: full 0 to 100 % ramp at increment 1, in ms
`define RAMP_FULL_FAST_MS  64'd37500
`define RAMP_FULL_SLOW_MS  64'd52200
`define DUTY_FULL_STEPS    64'd255
`define CLK_KHZ            64'd100000
`define SLOT_FAST_CYCLES   (`RAMP_FULL_FAST_MS * `CLK_KHZ / `DUTY_FULL_STEPS)
`define SLOT_SLOW_CYCLES   (`RAMP_FULL_SLOW_MS * `CLK_KHZ / `DUTY_FULL_STEPS)

`define DUTY_MAX           8'hff

`endif

// >>> fan_ramp_pkg.sv
package fan_ramp_pkg;

  typedef logic [7:0] duty_t;
  typedef logic [2:0] ramp_code_t;

  // Ramp code to per-slot duty increment
  function automatic duty_t ramp_incr(input ramp_code_t code);
    duty_t r;
    r = 8'h01;
    case (code)
      3'h0: r = 8'h01;
      3'h1: r = 8'h02;
      3'h2: r = 8'h03;
      3'h3: r = 8'h04;
      3'h4: r = 8'h08;
      3'h5: r = 8'h0c;
      3'h6: r = 8'h18;
      3'h7: r = 8'h30;
      default: r = 8'h01;
    endcase
    return r;
  endfunction

endpackage

// >>> ramp_stepper.sv
`timescale 1ns/1ps
`default_nettype none

module ramp_stepper (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  smooth_en,
  input  wire logic                  slot_tick,
  input  wire fan_ramp_pkg::duty_t   incr,
  input  wire fan_ramp_pkg::duty_t   target,
  output var   fan_ramp_pkg::duty_t  duty
);

  fan_ramp_pkg::duty_t duty_ff;
  fan_ramp_pkg::duty_t nxt_duty;
  fan_ramp_pkg::duty_t gap;
  logic                rising;
  logic                close;

  assign rising = target > duty_ff;
  assign gap    = rising ? (target - duty_ff) : (duty_ff - target);
  assign close  = gap <= incr;

  // Clamp the step so the duty never overshoots the target
  assign nxt_duty = !smooth_en ? target :
                    !slot_tick ? duty_ff :
                    close      ? target :
                    rising     ? duty_ff + incr : duty_ff - incr;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      duty_ff <= 8'h00;
    end else begin
      duty_ff <= nxt_duty;
    end
  end

  assign duty = duty_ff;

endmodule // ramp_stepper

`default_nettype wire

// >>> fan_ramp_properties.sv
`timescale 1ns/1ps
`default_nettype none
module fan_ramp_properties #(
  parameter int unsigned SLOT_FAST = 4,
  parameter int unsigned SLOT_SLOW = 6
) (
  input wire logic                clk,
  input wire logic                rst,
  input wire logic [7:0]          s_axi_awaddr,
  input wire logic                s_axi_awvalid,
  input wire logic                s_axi_awready,
  input wire logic [31:0]         s_axi_wdata,
  input wire logic [3:0]          s_axi_wstrb,
  input wire logic                s_axi_wvalid,
  input wire logic                s_axi_wready,
  input wire logic [1:0]          s_axi_bresp,
  input wire logic                s_axi_bvalid,
  input wire logic                s_axi_bready,
  input wire logic                s_axi_arvalid,
  input wire logic                s_axi_arready,
  input wire logic                s_axi_rvalid,
  input wire logic                s_axi_rready,
  input wire fan_ramp_pkg::duty_t local_request_duty,
  input wire fan_ramp_pkg::duty_t remote2_request_duty,
  input wire fan_ramp_pkg::duty_t fan_duty_level,
  input wire logic                fan_drive_output
);
  localparam logic [7:0] INC [8] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h08, 8'h0c, 8'h18, 8'h30};
  // Shadow of config writes; trails the design by a cycle, so antecedents skip switch-overs
  logic [7:0]  aw_ff, wd_ff, cfg_ff, lvl_ff;
  logic [4:0]  ctl_ff;
  logic [15:0] run_ff;
  logic        ws_ff;
  wire [7:0]  dlt = fan_duty_level > lvl_ff ? fan_duty_level - lvl_ff : lvl_ff - fan_duty_level;
  wire [7:0]  top = local_request_duty > remote2_request_duty ? local_request_duty : remote2_request_duty;
  wire        r2_only = cfg_ff[7] && !cfg_ff[3] && local_request_duty == 8'h00;
  wire        both_off = !cfg_ff[7] && !cfg_ff[3];
  wire [15:0] slot = ctl_ff[0] ? 16'(SLOT_SLOW) : 16'(SLOT_FAST);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {aw_ff, wd_ff, cfg_ff, lvl_ff, ctl_ff, run_ff, ws_ff} <= '0;
    end else begin
      lvl_ff <= fan_duty_level;
      if (dlt != 8'h00) run_ff <= 16'h0000;
      else if (run_ff != 16'hffff) run_ff <= run_ff + 16'h0001;
      if (s_axi_awvalid && s_axi_awready) aw_ff <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) wd_ff <= s_axi_wdata[7:0];
      if (s_axi_wvalid && s_axi_wready) ws_ff <= s_axi_wstrb[0];
      if ($rose(s_axi_bvalid) && ws_ff && !ctl_ff[1] && aw_ff == 8'h00) cfg_ff <= wd_ff;
      if ($rose(s_axi_bvalid) && ws_ff && !ctl_ff[1] && aw_ff == 8'h04) ctl_ff <= wd_ff[4:0];
    end
  end
  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write answer late");
  a_resp_clear: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer not cleared");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_off_follow: assert property ((both_off && $stable(local_request_duty)
    && $stable(remote2_request_duty)) [*4] |-> fan_duty_level == top) else $error("duty not applied at once");
  a_r2_step: assert property (r2_only |-> dlt <= INC[cfg_ff[6:4]])
    else $error("duty step too large");
  a_slot_space: assert property (r2_only && dlt != 8'h00 && $stable(cfg_ff) && $stable(ctl_ff)
    |-> run_ff >= slot - 16'h0001) else $error("duty steps too close");
  a_full_drive: assert property ((fan_duty_level == 8'hff) [*2] |-> fan_drive_output)
    else $error("drive low at full duty");
  a_zero_drive: assert property ((fan_duty_level == 8'h00) [*2] |-> !fan_drive_output)
    else $error("drive high at zero duty");
  c_r2_step: cover property (r2_only && dlt != 8'h00);
  c_full: cover property (fan_duty_level == 8'hff);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule // fan_ramp_properties
`default_nettype wire

// >>> fan_pwm_ramp_smoothing_tb.sv
`timescale 1ns/1ps
`default_nettype none
module fan_pwm_ramp_smoothing_tb;
  localparam int unsigned SLOT_FAST = 4;
  localparam int unsigned SLOT_SLOW = 6;
  logic clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, fan_drive_output;
  logic [7:0]          s_axi_awaddr, s_axi_araddr;
  logic [31:0]         s_axi_wdata, s_axi_rdata, seed, rdat, x;
  logic [3:0]          s_axi_wstrb;
  logic [1:0]          s_axi_bresp, s_axi_rresp, resp;
  fan_ramp_pkg::duty_t local_request_duty, remote2_request_duty, fan_duty_level;
  int                  fails, n_tests;

  fan_pwm_ramp_smoothing #(.SLOT_FAST(SLOT_FAST), .SLOT_SLOW(SLOT_SLOW)) u_fan_pwm_ramp_smoothing (
    .clk                  (clk),
    .rst                  (rst),
    .s_axi_awaddr         (s_axi_awaddr),
    .s_axi_awvalid        (s_axi_awvalid),
    .s_axi_awready        (s_axi_awready),
    .s_axi_wdata          (s_axi_wdata),
    .s_axi_wstrb          (s_axi_wstrb),
    .s_axi_wvalid         (s_axi_wvalid),
    .s_axi_wready         (s_axi_wready),
    .s_axi_bresp          (s_axi_bresp),
    .s_axi_bvalid         (s_axi_bvalid),
    .s_axi_bready         (s_axi_bready),
    .s_axi_araddr         (s_axi_araddr),
    .s_axi_arvalid        (s_axi_arvalid),
    .s_axi_arready        (s_axi_arready),
    .s_axi_rdata          (s_axi_rdata),
    .s_axi_rresp          (s_axi_rresp),
    .s_axi_rvalid         (s_axi_rvalid),
    .s_axi_rready         (s_axi_rready),
    .local_request_duty   (local_request_duty),
    .remote2_request_duty (remote2_request_duty),
    .fan_duty_level       (fan_duty_level),
    .fan_drive_output     (fan_drive_output)
  );

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Slots to close a gap; the last one is clipped, never overshoots
  function automatic int steps_of(input int gap, input int code);
    int t[8];
    t = '{1, 2, 3, 4, 8, 12, 24, 48};
    return (gap + t[code] - 1) / t[code];
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit pa, pw;
    pa = 1;
    pw = 1;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (pa || pw) begin
      @(posedge clk);
      if (pa && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (pa && s_axi_awready) pa = 0;
      if (pw && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (pw && s_axi_wready) pw = 0;
    end
    while (!s_axi_bvalid) @(posedge clk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // One channel ramps from s to t; the other is parked at zero so it cannot mask the level
  task automatic ramp(input bit ch, input int code, input bit slow);
    int s, t, o, st, n, w;
    logic [31:0] hi;
    s = int'(rnd() & 32'hff);
    t = int'(rnd() & 32'hff);
    o = int'(rnd() & 32'hff);
    if (code == 7) s = 0;
    if (code == 7) t = 32'hff;
    if (t == s) t = 32'hff - s;
    axi_wr(8'h00, 32'h00, resp);
    @(posedge clk);
    remote2_request_duty <= 8'(ch ? s : o);
    local_request_duty <= 8'(ch ? o : s);
    repeat (4) @(posedge clk);
    chk(fan_duty_level, 32'(s > o ? s : o));
    if (ch) local_request_duty <= 8'h00;
    else remote2_request_duty <= 8'h00;
    axi_wr(8'h04, 32'(code << 2) | 32'(slow), resp);
    axi_wr(8'h00, ch ? (32'(code << 4) | 32'h80) : 32'h08, resp);
    @(posedge clk);
    if (ch) remote2_request_duty <= 8'(t);
    else local_request_duty <= 8'(t);
    st = slow ? SLOT_SLOW : SLOT_FAST;
    n = steps_of(t > s ? t - s : s - t, code);
    w = 0;
    while (fan_duty_level !== 8'(t) && w < 2000) begin
      @(posedge clk);
      w++;
    end
    chk(w >= (n - 1) * st && w <= n * st + 3, 1'b1);
    axi_rd(8'h08, rdat, resp);
    chk(rdat, (32'(t) << 16) | (ch ? (32'(t) << 8) : 32'(t)));
    hi = 32'h0;
    repeat (256) begin
      @(posedge clk);
      hi = hi + {31'h0, fan_drive_output};
    end
    chk(hi, (t == 255) ? 32'h100 : 32'(t));
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (80000) @(posedge clk);
    fails++;
    close_out();
  end

  initial begin
    seed = 32'hef468968;
    fails = 0;
    n_tests = 0;
    rst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    local_request_duty = 8'h00;
    remote2_request_duty = 8'h00;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    axi_rd(8'h00, rdat, resp);
    chk(rdat, 32'h00);
    axi_rd(8'h04, rdat, resp);
    chk(rdat, 32'h00);
    axi_wr(8'h0c, 32'h01, resp);
    chk(resp, 2'h2);
    axi_rd(8'h0c, rdat, resp);
    chk({rdat[29:0], resp}, 32'h02);
    for (int i = 0; i < 32; i++) begin
      ramp(i[4], i % 8, i[3]);
    end
    x = rnd() & 32'hff;
    axi_wr(8'h00, x, resp);
    axi_rd(8'h00, rdat, resp);
    chk(rdat, x);
    s_axi_wstrb <= 4'he;
    axi_wr(8'h00, x ^ 32'hff, resp);
    s_axi_wstrb <= 4'hf;
    axi_wr(8'h08, 32'hff, resp);
    chk(resp, 2'h0);
    axi_rd(8'h00, rdat, resp);
    chk(rdat, x);
    axi_wr(8'h04, 32'h02, resp);
    axi_wr(8'h00, x ^ 32'hff, resp);
    chk(resp, 2'h0);
    axi_rd(8'h00, rdat, resp);
    chk(rdat, x);
    axi_wr(8'h04, 32'h00, resp);
    axi_rd(8'h04, rdat, resp);
    chk(rdat, 32'h02);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    axi_rd(8'h04, rdat, resp);
    chk(rdat, 32'h00);
    axi_wr(8'h00, x ^ 32'hff, resp);
    axi_rd(8'h00, rdat, resp);
    chk(rdat, x ^ 32'hff);
    close_out();
  end
endmodule // fan_pwm_ramp_smoothing_tb

bind fan_pwm_ramp_smoothing fan_ramp_properties #(.SLOT_FAST(SLOT_FAST), .SLOT_SLOW(SLOT_SLOW)) u_fan_ramp_properties (
  .clk                  (clk),
  .rst                  (rst),
  .s_axi_awaddr         (s_axi_awaddr),
  .s_axi_awvalid        (s_axi_awvalid),
  .s_axi_awready        (s_axi_awready),
  .s_axi_wdata          (s_axi_wdata),
  .s_axi_wstrb          (s_axi_wstrb),
  .s_axi_wvalid         (s_axi_wvalid),
  .s_axi_wready         (s_axi_wready),
  .s_axi_bresp          (s_axi_bresp),
  .s_axi_bvalid         (s_axi_bvalid),
  .s_axi_bready         (s_axi_bready),
  .s_axi_arvalid        (s_axi_arvalid),
  .s_axi_arready        (s_axi_arready),
  .s_axi_rvalid         (s_axi_rvalid),
  .s_axi_rready         (s_axi_rready),
  .local_request_duty   (local_request_duty),
  .remote2_request_duty (remote2_request_duty),
  .fan_duty_level       (fan_duty_level),
  .fan_drive_output     (fan_drive_output)
);
`default_nettype wire
